// ---- verilog/lpas_top.v ----
// Lead polarity selection and per-chamber automatic sensitivity control.
`timescale 1ns/1ps
`include "lpas_defs.vh"

module lpas_top
#(
	parameter MS_CYCLES = `LPAS_MS_NS / `LPAS_CLK_NS
)
(
	// Clock and reset
	input  wire        clk_sys,
	input  wire        sys_rst,
	// Register port
	input  wire [3:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [15:0] reg_rdata,
	// Lead detection pins and lead check
	input  wire        lead_bip_a,
	input  wire        lead_bip_v,
	input  wire        lead_fail_a,
	input  wire        lead_fail_v,
	// Digitized intracardiac electrogram
	input  wire        smp_vld,
	input  wire [11:0] intracardiac_electrogram_a,
	input  wire [11:0] intracardiac_electrogram_v,
	// Polarity outputs
	output reg         pace_bip_a,
	output reg         pace_bip_v,
	output reg         sense_bip_a,
	output reg         sense_bip_v,
	// Sensed events
	output reg         sensed_a,
	output reg         sensed_v
);

	// ----------------------------------------
	// States and helpers
	// ----------------------------------------
	localparam S_WAIT = 2'b00;
	localparam S_HOLD = 2'b01;
	localparam S_STEP = 2'b10;

	function [11:0] floor_sel;
		input chamber;
		input bipolar;
		begin
			if (chamber)
				floor_sel = `LPAS_FLOOR_V;
			else if (bipolar)
				floor_sel = `LPAS_FLOOR_A_BIP;
			else
				floor_sel = `LPAS_FLOOR_A_UNI;
		end
	endfunction

	function [11:0] clamp_floor;
		input [11:0] value;
		input [11:0] floor_val;
		begin
			clamp_floor = (value < floor_val) ? floor_val : value;
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	reg [1:0] det_meta_reg;
	reg [1:0] det_reg;

	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			det_meta_reg <= 2'b00;
			det_reg      <= 2'b00;
		end
		else
		begin
			det_meta_reg <= {lead_bip_v, lead_bip_a};
			det_reg      <= det_meta_reg;
		end
	end

	// ----------------------------------------
	// Millisecond tick
	// ----------------------------------------
	reg  [15:0] ms_cnt_reg;
	reg         tick_reg;

	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			ms_cnt_reg <= 16'h0000;
			tick_reg   <= 1'b0;
		end
		else if (ms_cnt_reg == MS_CYCLES[15:0] - 16'h0001)
		begin
			ms_cnt_reg <= 16'h0000;
			tick_reg   <= 1'b1;
		end
		else
		begin
			ms_cnt_reg <= ms_cnt_reg + 16'h0001;
			tick_reg   <= 1'b0;
		end
	end

	// ----------------------------------------
	// Control and polarity registers
	// ----------------------------------------
	reg  [1:0]  auto_reg;
	reg  [3:0]  pol_reg;
	reg  [3:0]  pol_next;
	reg         prog_reg;
	reg  [11:0] fix_a_reg;
	reg  [11:0] fix_v_reg;
	wire        wr_ctrl;
	wire        wr_pol;
	wire        init_go;
	wire [1:0]  hit;

	assign wr_ctrl = reg_wr && (reg_addr == `LPAS_ADDR_CTRL);
	assign wr_pol  = reg_wr && (reg_addr == `LPAS_ADDR_POL);
	assign init_go = wr_ctrl && reg_wdata[`LPAS_CTRL_INIT];

	always @*
	begin
		pol_next = pol_reg;
		if (wr_pol)
			pol_next = reg_wdata[3:0];
		else if (init_go && !prog_reg)
			pol_next = {det_reg[1], det_reg[0], det_reg[1], det_reg[0]};
		if (lead_fail_a)
			pol_next[`LPAS_POL_PACE_A] = 1'b0;
		if (lead_fail_v)
			pol_next[`LPAS_POL_PACE_V] = 1'b0;
	end

	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			auto_reg  <= `LPAS_CTRL_RST;
			pol_reg   <= 4'h0;
			prog_reg  <= 1'b0;
			fix_a_reg <= `LPAS_FIX_RST;
			fix_v_reg <= `LPAS_FIX_RST;
		end
		else
		begin
			pol_reg <= pol_next;
			if (wr_pol)
				prog_reg <= 1'b1;
			if (wr_ctrl)
				auto_reg <= reg_wdata[`LPAS_CTRL_AUTO_V:`LPAS_CTRL_AUTO_A];
			if (reg_wr && (reg_addr == `LPAS_ADDR_FIX_A))
				fix_a_reg <= reg_wdata[11:0];
			if (reg_wr && (reg_addr == `LPAS_ADDR_FIX_V))
				fix_v_reg <= reg_wdata[11:0];
		end
	end

	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			pace_bip_a  <= 1'b0;
			pace_bip_v  <= 1'b0;
			sense_bip_a <= 1'b0;
			sense_bip_v <= 1'b0;
			sensed_a    <= 1'b0;
			sensed_v    <= 1'b0;
		end
		else
		begin
			pace_bip_a  <= pol_reg[`LPAS_POL_PACE_A];
			pace_bip_v  <= pol_reg[`LPAS_POL_PACE_V];
			sense_bip_a <= pol_reg[`LPAS_POL_SENSE_A];
			sense_bip_v <= pol_reg[`LPAS_POL_SENSE_V];
			sensed_a    <= hit[0];
			sensed_v    <= hit[1];
		end
	end

	// ----------------------------------------
	// Filtered magnitude per chamber
	// ----------------------------------------
	wire [1:0]  mag_vld;
	wire [23:0] mag_flat;
	wire [23:0] fix_flat;
	wire [23:0] thr_flat;
	wire [23:0] peak_flat;
	wire [3:0]  st_flat;
	wire [23:0] smp_flat;

	assign smp_flat = {intracardiac_electrogram_v, intracardiac_electrogram_a};
	assign fix_flat = {fix_v_reg, fix_a_reg};

	// ----------------------------------------
	// Threshold adaptation per chamber
	// ----------------------------------------
	genvar c;
	generate
		for (c = 0; c < 2; c = c + 1)
		begin : g_ch
			reg  [1:0]  st_reg;
			reg  [9:0]  tm_reg;
			reg  [9:0]  quiet_reg;
			reg  [11:0] peak_reg;
			reg  [11:0] thr_reg;
			wire [11:0] mag;
			wire [11:0] floor_val;
			wire [11:0] thr_use;
			wire [9:0]  hold_ms;
			wire [9:0]  step_ms;
			wire        auto_on;

			lpas_bpf u_bpf
			(
				.clk_sys (clk_sys),
				.sys_rst (sys_rst),
				.smp_vld (smp_vld),
				.smp_in  (smp_flat[c*12 +: 12]),
				.mag_vld (mag_vld[c]),
				.mag_out (mag_flat[c*12 +: 12])
			);

			assign mag       = mag_flat[c*12 +: 12];
			assign auto_on   = auto_reg[c];
			assign floor_val = floor_sel(c == 1, pol_reg[`LPAS_POL_SENSE_A + c]);
			assign hold_ms   = c ? `LPAS_HOLD_V_MS : `LPAS_HOLD_A_MS;
			assign step_ms   = c ? `LPAS_STEP_V_MS : `LPAS_STEP_A_MS;
			assign thr_use   = auto_on ? thr_reg : fix_flat[c*12 +: 12];
			assign hit[c]    = mag_vld[c] && (st_reg != S_HOLD) && (mag >= thr_use);

			always @(posedge clk_sys)
			begin
				if (sys_rst)
				begin
					st_reg    <= S_WAIT;
					tm_reg    <= 10'h000;
					quiet_reg <= 10'h000;
					peak_reg  <= 12'h000;
					thr_reg   <= `LPAS_FLOOR_V;
				end
				else if (hit[c])
				begin
					st_reg    <= S_HOLD;
					tm_reg    <= 10'h000;
					quiet_reg <= 10'h000;
					peak_reg  <= auto_on ? mag : peak_reg;
				end
				else
				begin
					if (tick_reg && (quiet_reg != `LPAS_PAUSE_MS))
						quiet_reg <= quiet_reg + 10'h001;
					case (st_reg)
						S_HOLD:
						begin
							if (auto_on && mag_vld[c] && (mag > peak_reg))
								peak_reg <= mag;
							if (tick_reg)
							begin
								if (tm_reg + 10'h001 >= hold_ms)
								begin
									st_reg <= auto_on ? S_STEP : S_WAIT;
									tm_reg <= 10'h000;
									if (auto_on)
										thr_reg <= clamp_floor({1'b0, peak_reg[11:1]}, floor_val);
								end
								else
									tm_reg <= tm_reg + 10'h001;
							end
						end
						S_STEP:
						begin
							if (tick_reg)
							begin
								if (tm_reg + 10'h001 >= step_ms)
								begin
									st_reg  <= S_WAIT;
									tm_reg  <= 10'h000;
									thr_reg <= clamp_floor({2'b00, peak_reg[11:2]}, floor_val);
								end
								else
									tm_reg <= tm_reg + 10'h001;
							end
						end
						S_WAIT:
						begin
							if (tick_reg && (quiet_reg + 10'h001 >= `LPAS_PAUSE_MS))
								thr_reg <= floor_val;
							else if (thr_reg < floor_val)
								thr_reg <= floor_val;
						end
						default: st_reg <= S_WAIT;
					endcase
				end
			end

			assign thr_flat[c*12 +: 12]  = thr_use;
			assign peak_flat[c*12 +: 12] = peak_reg;
			assign st_flat[c*2 +: 2]     = st_reg;
		end
	endgenerate

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	always @(posedge clk_sys)
	begin
		if (sys_rst)
			reg_rdata <= 16'h0000;
		else if (reg_rd)
		begin
			case (reg_addr)
				`LPAS_ADDR_CTRL:   reg_rdata <= {14'h0000, auto_reg};
				`LPAS_ADDR_POL:    reg_rdata <= {12'h000, pol_reg};
				`LPAS_ADDR_FIX_A:  reg_rdata <= {4'h0, fix_a_reg};
				`LPAS_ADDR_FIX_V:  reg_rdata <= {4'h0, fix_v_reg};
				`LPAS_ADDR_THR_A:  reg_rdata <= {4'h0, thr_flat[11:0]};
				`LPAS_ADDR_THR_V:  reg_rdata <= {4'h0, thr_flat[23:12]};
				`LPAS_ADDR_PEAK_A: reg_rdata <= {4'h0, peak_flat[11:0]};
				`LPAS_ADDR_PEAK_V: reg_rdata <= {4'h0, peak_flat[23:12]};
				`LPAS_ADDR_STAT:   reg_rdata <= {9'h000, prog_reg, st_flat, det_reg};
				default:           reg_rdata <= 16'h0000;
			endcase
		end
		else
			reg_rdata <= 16'h0000;
	end

endmodule // lpas_top

// ---- inc/lpas_defs.vh ----
// Constants for the lead polarity and automatic sensitivity block.
// Summary of operation
// - Auto-initialization sets lead polarity from the detected connected leads.
// - A polarity programmed before auto-initialization is kept instead.
// - Pacing and sensing polarity are held separately; all combinations accepted.
// - With bipolar leads, bipolar or unipolar may be selected.
// - Reset or a detected lead failure may force pacing to unipolar.
// - Atrial and ventricular thresholds adapt independently on every event.
// - The electrogram passes an 18 to 100 Hz band-pass before sensing.
// - Fixed and automatic thresholds use the same filtered signal path.
// - A sensed event in automatic mode starts hold-off and peak capture.
// - After hold-off the threshold is half the peak for one step.
// - After the step the threshold is a quarter peak, never below floor.
// - Atrium uses 100 ms hold-off and 80 ms step.
// - Ventricle uses 120 ms hold-off and 125 ms step.
// - Floor is 2.0 mV ventricle; atrium 0.2 mV bipolar, 0.5 mV unipolar.
// - One second without sensing drops the threshold to its floor.
`ifndef LPAS_DEFS_VH
`define LPAS_DEFS_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define LPAS_CLK_NS       20
`define LPAS_MS_NS        1000000
`define LPAS_HOLD_A_MS    10'd100
`define LPAS_STEP_A_MS    10'd80
`define LPAS_HOLD_V_MS    10'd120
`define LPAS_STEP_V_MS    10'd125
`define LPAS_PAUSE_MS     10'd1000

// ----------------------------------------
// Amplitudes, 10 uV per step
// ----------------------------------------
`define LPAS_FLOOR_V      12'h0C8
`define LPAS_FLOOR_A_BIP  12'h014
`define LPAS_FLOOR_A_UNI  12'h032
`define LPAS_FIX_RST      12'h0C8
`define LPAS_MAG_MAX      12'hFFF

// ----------------------------------------
// Band-pass filter shifts
// ----------------------------------------
`define LPAS_HP_SHIFT     3
`define LPAS_LP_SHIFT     1

// ----------------------------------------
// Register map
// ----------------------------------------
`define LPAS_ADDR_CTRL    4'h0
`define LPAS_ADDR_POL     4'h1
`define LPAS_ADDR_FIX_A   4'h2
`define LPAS_ADDR_FIX_V   4'h3
`define LPAS_ADDR_THR_A   4'h4
`define LPAS_ADDR_THR_V   4'h5
`define LPAS_ADDR_PEAK_A  4'h6
`define LPAS_ADDR_PEAK_V  4'h7
`define LPAS_ADDR_STAT    4'h8

// ----------------------------------------
// Field positions and control reset value
// ----------------------------------------
`define LPAS_CTRL_AUTO_A  0
`define LPAS_CTRL_AUTO_V  1
`define LPAS_CTRL_INIT    2
`define LPAS_CTRL_RST     2'h3
`define LPAS_POL_PACE_A   0
`define LPAS_POL_PACE_V   1
`define LPAS_POL_SENSE_A  2
`define LPAS_POL_SENSE_V  3

`endif

// ---- verilog/lpas_bpf.v ----
// Band-pass filter and magnitude stage for one electrogram channel.
`timescale 1ns/1ps
`include "lpas_defs.vh"

module lpas_bpf
(
	// Clock and reset
	input  wire        clk_sys,
	input  wire        sys_rst,
	// Digitized samples
	input  wire        smp_vld,
	input  wire [11:0] smp_in,
	// Filtered magnitude
	output reg         mag_vld,
	output reg  [11:0] mag_out
);

	// ----------------------------------------
	// Filter state
	// ----------------------------------------
	reg  signed [13:0] slow_reg;
	reg  signed [13:0] lp_reg;
	wire signed [13:0] x_ext;
	wire signed [13:0] hp;
	wire signed [13:0] slow_next;
	wire signed [13:0] lp_next;
	wire        [13:0] abs_lp;

	assign x_ext     = {{2{smp_in[11]}}, smp_in};
	assign hp        = x_ext - slow_reg;
	assign slow_next = slow_reg + (hp >>> `LPAS_HP_SHIFT);
	assign lp_next   = lp_reg + ((hp - lp_reg) >>> `LPAS_LP_SHIFT);
	assign abs_lp    = lp_next[13] ? (14'h0000 - lp_next) : lp_next;

	// ----------------------------------------
	// High-pass then low-pass per sample
	// ----------------------------------------
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			slow_reg <= 14'h0000;
			lp_reg   <= 14'h0000;
			mag_vld  <= 1'b0;
			mag_out  <= 12'h000;
		end
		else
		begin
			mag_vld <= smp_vld;
			if (smp_vld)
			begin
				slow_reg <= slow_next;
				lp_reg   <= lp_next;
				mag_out  <= (abs_lp[13:12] != 2'b00) ? `LPAS_MAG_MAX : abs_lp[11:0];
			end
		end
	end

endmodule // lpas_bpf

// ---- tb/lpas_top_asserts.sv ----
// Checker of the polarity and sensing ports of the top block.
`timescale 1ns/1ps
module lpas_top_asserts
#(
	parameter MS_CYCLES = 10
)
(
	// Clock and reset
	input wire        clk_sys,
	input wire        sys_rst,
	// Register port and lead check
	input wire        reg_wr,
	input wire [3:0]  reg_addr,
	input wire [15:0] reg_wdata,
	input wire        lead_fail_a,
	input wire        lead_fail_v,
	// Samples and outputs
	input wire        smp_vld,
	input wire        pace_bip_a,
	input wire        pace_bip_v,
	input wire        sense_bip_a,
	input wire        sense_bip_v,
	input wire        sensed_a,
	input wire        sensed_v
);
	int gap_a = 1000000;
	int gap_v = 1000000;

	// Counts cycles since the last sensed pulse of each chamber.
	always @(posedge clk_sys)
	begin
		gap_a <= sys_rst ? 1000000 : (sensed_a ? 0 : gap_a + 1);
		gap_v <= sys_rst ? 1000000 : (sensed_v ? 0 : gap_v + 1);
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	sequence s_pol_wr;
		reg_wr && reg_addr == 4'h1 && !lead_fail_a && !lead_fail_v;
	endsequence
	sequence s_quiet;
		!reg_wr && !lead_fail_a && !lead_fail_v;
	endsequence

	AST_POL_WRITE: assert property (s_pol_wr ##1 s_quiet |=>
		{sense_bip_v, sense_bip_a, pace_bip_v, pace_bip_a} == $past(reg_wdata[3:0], 2))
		else $error("Polarity outputs differ from written value.");
	AST_FAIL_A: assert property (lead_fail_a |-> ##2 !pace_bip_a) else $error("Atrial pacing not unipolar.");
	AST_FAIL_V: assert property (lead_fail_v |-> ##2 !pace_bip_v) else $error("Ventricular pacing not unipolar.");
	AST_RST_UNI: assert property ($fell(sys_rst) |-> !pace_bip_a && !pace_bip_v)
		else $error("Pacing not unipolar after reset.");
	AST_SRC_A: assert property (sensed_a |-> $past(smp_vld, 2)) else $error("Atrial sense without sample.");
	AST_SRC_V: assert property (sensed_v |-> $past(smp_vld, 2)) else $error("Ventricular sense without sample.");
	AST_HOLD_A: assert property (sensed_a |-> gap_a >= 99 * MS_CYCLES - 2)
		else $error("Atrial sense inside hold-off.");
	AST_HOLD_V: assert property (sensed_v |-> gap_v >= 119 * MS_CYCLES - 2)
		else $error("Ventricular sense inside hold-off.");
endmodule // lpas_top_asserts

bind lpas_top lpas_top_asserts #(.MS_CYCLES(MS_CYCLES)) u_lpas_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .lead_fail_a(lead_fail_a),
	.lead_fail_v(lead_fail_v), .smp_vld(smp_vld), .pace_bip_a(pace_bip_a), .pace_bip_v(pace_bip_v),
	.sense_bip_a(sense_bip_a), .sense_bip_v(sense_bip_v), .sensed_a(sensed_a), .sensed_v(sensed_v));

// ---- tb/lpas_heart_model.sv ----
// Model of the leads and digitizer, one sample per millisecond.
`timescale 1ns/1ps
module lpas_heart_model
#(
	parameter MS_CYCLES = 10
)
(
	// Clock and reset
	input  wire        clk_sys,
	input  wire        sys_rst,
	// Lead type and beat requests
	input  wire        bip_a,
	input  wire        bip_v,
	input  wire        beat_a,
	input  wire        beat_v,
	// Lead pins and samples
	output reg         lead_bip_a = 1'b0,
	output reg         lead_bip_v = 1'b0,
	output reg         smp_vld = 1'b0,
	output wire [11:0] egm_a,
	output wire [11:0] egm_v
);
	reg [11:0] smp_a_reg = 12'h000;
	reg [11:0] smp_v_reg = 12'h000;
	reg        pend_a_reg = 1'b0;
	reg        pend_v_reg = 1'b0;
	integer    div_reg = 0;

	// Sample lines are only valid with the strobe, so they toggle in between.
	assign egm_a = smp_vld ? smp_a_reg : ~smp_a_reg;
	assign egm_v = smp_vld ? smp_v_reg : ~smp_v_reg;

	always @(posedge clk_sys)
	begin
		lead_bip_a <= bip_a;
		lead_bip_v <= bip_v;
		smp_vld <= 1'b0;
		div_reg <= div_reg + 1;
		pend_a_reg <= pend_a_reg | beat_a;
		pend_v_reg <= pend_v_reg | beat_v;
		if (div_reg == MS_CYCLES - 1)
		begin
			div_reg <= 0;
			smp_vld <= 1'b1;
			smp_a_reg <= pend_a_reg ? 12'h7FF : 12'h000;
			smp_v_reg <= pend_v_reg ? 12'h7FF : 12'h000;
			pend_a_reg <= beat_a;
			pend_v_reg <= beat_v;
		end
		if (sys_rst)
		begin
			div_reg <= 0;
			pend_a_reg <= 1'b0;
			pend_v_reg <= 1'b0;
		end
	end
endmodule // lpas_heart_model

// ---- tb/tb.sv ----
// Self-checking bench of the polarity and sensing block.
`timescale 1ns/1ps
module tb;
	localparam MS = 10;
	// A full-scale beat on a settled channel gives this first filtered magnitude.
	localparam [15:0] PEAK = 16'h03FF;
	localparam [159:0] RST_TAB = {20'h00003, 20'h10000, 20'h200C8, 20'h300C8, 20'h400C8, 20'h500C8,
		20'h80001, 20'h90000};
	reg         clk_sys = 1'b0;
	reg         sys_rst = 1'b1;
	reg  [3:0]  reg_addr = 4'h0;
	reg  [15:0] reg_wdata = 16'h0000;
	reg         reg_wr = 1'b0;
	reg         reg_rd = 1'b0;
	reg         beat_a = 1'b0;
	reg         beat_v = 1'b0;
	reg         bip_a = 1'b1;
	reg         bip_v = 1'b0;
	reg         lead_fail_a = 1'b0;
	reg         lead_fail_v = 1'b0;
	reg  [15:0] d;
	integer     i;
	integer     failures = 0;
	integer     comparisons = 0;
	wire [15:0] reg_rdata;
	wire [11:0] egm_a;
	wire [11:0] egm_v;
	wire        lead_bip_a, lead_bip_v, smp_vld;
	wire        pace_bip_a, pace_bip_v, sense_bip_a, sense_bip_v, sensed_a, sensed_v;

	always #10 clk_sys = ~clk_sys;

	lpas_heart_model #(.MS_CYCLES(MS)) u_heart (.clk_sys(clk_sys), .sys_rst(sys_rst), .bip_a(bip_a),
		.bip_v(bip_v), .beat_a(beat_a), .beat_v(beat_v), .lead_bip_a(lead_bip_a), .lead_bip_v(lead_bip_v),
		.smp_vld(smp_vld), .egm_a(egm_a), .egm_v(egm_v));
	lpas_top #(.MS_CYCLES(MS)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.lead_bip_a(lead_bip_a), .lead_bip_v(lead_bip_v), .lead_fail_a(lead_fail_a), .lead_fail_v(lead_fail_v),
		.smp_vld(smp_vld), .intracardiac_electrogram_a(egm_a), .intracardiac_electrogram_v(egm_v),
		.pace_bip_a(pace_bip_a), .pace_bip_v(pace_bip_v), .sense_bip_a(sense_bip_a),
		.sense_bip_v(sense_bip_v), .sensed_a(sensed_a), .sensed_v(sensed_v));

	task give_verdict;
	begin
		if (failures == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask

	task chk(input string name, input [15:0] exp, input [15:0] got);
	begin
		comparisons = comparisons + 1;
		if (got !== exp)
		begin
			failures = failures + 1;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	end
	endtask

	function [15:0] mx(input [15:0] a, input [15:0] b);
		mx = (a > b) ? a : b;
	endfunction

	task wr(input [3:0] a, input [15:0] v);
	begin
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	end
	endtask

	task rd(input [3:0] a);
	begin
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	end
	endtask

	task pol(input [3:0] e);
	begin
		repeat (2) @(posedge clk_sys);
		#1 chk("pol_out", {12'h000, e}, {12'h000, sense_bip_v, sense_bip_a, pace_bip_v, pace_bip_a});
	end
	endtask

	task ms(input integer n);
		repeat (n * MS) @(posedge clk_sys);
	endtask

	task beat(input ch);
	begin
		@(posedge clk_sys);
		beat_a <= !ch;
		beat_v <= ch;
		@(posedge clk_sys);
		beat_a <= 1'b0;
		beat_v <= 1'b0;
	end
	endtask

	task sense_wait(input ch);
		integer n;
	begin
		for (n = 0; n < 40 && (ch ? sensed_v : sensed_a) !== 1'b1; n = n + 1)
			@(negedge clk_sys);
		if (n == 40)
		begin
			failures = failures + 1;
			give_verdict;
		end
	end
	endtask

	task track(input ch, input integer hold, input integer step, input [15:0] flr);
	begin
		beat(ch);
		sense_wait(ch);
		ms(50);
		beat(ch);
		ms(hold - 52);
		rd(4'h8);
		chk("state", 16'h0001, (d >> (2 + 2 * ch)) & 3);
		ms(4);
		rd(4'h8);
		chk("state", 16'h0002, (d >> (2 + 2 * ch)) & 3);
		rd(ch ? 4'h7 : 4'h6);
		chk("peak", PEAK, d);
		rd(ch ? 4'h5 : 4'h4);
		chk("thr_half", mx(PEAK >> 1, flr), d);
		rd(4'h5);
		if (!ch)
			chk("thr_v", 16'h00C8, d);
		ms(step);
		rd(4'h8);
		chk("state", 16'h0000, (d >> (2 + 2 * ch)) & 3);
		rd(ch ? 4'h5 : 4'h4);
		chk("thr_qtr", mx(PEAK >> 2, flr), d);
		ms(1000 - hold - step);
		rd(ch ? 4'h5 : 4'h4);
		chk("thr_floor", flr, d);
	end
	endtask

	initial
	begin
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		ms(3);
		wr(4'h4, 16'h0FFF);
		wr(4'h9, 16'hFFFF);
		for (i = 0; i < 8; i = i + 1)
		begin
			rd(RST_TAB[i * 20 + 16 +: 4]);
			chk("reset", RST_TAB[i * 20 +: 16], d);
		end
		wr(4'h0, 16'h0007);
		pol(4'h5);
		rd(4'h0);
		chk("ctrl", 16'h0003, d);
		for (i = 0; i < 16; i = i + 1)
		begin
			wr(4'h1, i[15:0]);
			pol(i[3:0]);
			rd(4'h1);
			chk("pol_reg", i[15:0], d);
		end
		wr(4'h1, 16'h0004);
		wr(4'h0, 16'h0007);
		pol(4'h4);
		rd(4'h8);
		chk("stat", 16'h0041, d);
		wr(4'h1, 16'h000F);
		@(posedge clk_sys);
		lead_fail_a <= 1'b1;
		lead_fail_v <= 1'b1;
		@(posedge clk_sys);
		lead_fail_a <= 1'b0;
		lead_fail_v <= 1'b0;
		pol(4'hC);
		wr(4'h1, 16'h0004);
		track(1'b0, 100, 80, 16'h0014);
		track(1'b1, 120, 125, 16'h00C8);
		wr(4'h1, 16'h0000);
		track(1'b0, 100, 80, 16'h0032);
		wr(4'h0, 16'h0002);
		wr(4'h2, 16'h0100);
		rd(4'h4);
		chk("thr_fix", 16'h0100, d);
		beat(1'b0);
		sense_wait(1'b0);
		ms(110);
		rd(4'h4);
		chk("thr_fix", 16'h0100, d);
		@(posedge clk_sys);
		bip_a <= 1'b0;
		bip_v <= 1'b1;
		sys_rst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		pol(4'h0);
		rd(4'h8);
		chk("stat", 16'h0002, d);
		wr(4'h0, 16'h0004);
		pol(4'hA);
		give_verdict;
	end
endmodule // tb
